// [hw/motor_param_defs.svh]
// Purpose: command codes, field positions, reset values of the bank
// Assumes: 8-bit command codes, 12-bit register fields
// Notes:   definitions only
`ifndef MOTOR_PARAM_DEFS_SVH
`define MOTOR_PARAM_DEFS_SVH

`define FIELD_W            12
`define CODE_W             8
`define LOCK_W             8

// read codes
`define RD_DRIVE_AMP       8'h02
`define RD_REGEN_AMP       8'h03
`define RD_RISE_RAMP       8'h04
`define RD_FALL_RAMP       8'h05
`define RD_UV_CUTOUT       8'h06
`define RD_UV_RESUME       8'h07
`define RD_OV_RESUME       8'h08
`define RD_OV_CUTOUT       8'h09
`define RD_HEATSINK        8'h0A
`define RD_BOARD           8'h0B
`define RD_SUPPLY          8'h10
`define RD_STATUS          8'h30
`define RD_LOCK            8'h31
`define RD_SAVE            8'h32

// write codes
`define WR_DRIVE_AMP       8'h42
`define WR_REGEN_AMP       8'h43
`define WR_RISE_RAMP       8'h44
`define WR_FALL_RAMP       8'h45
`define WR_UV_CUTOUT       8'h46
`define WR_UV_RESUME       8'h47
`define WR_OV_RESUME       8'h48
`define WR_OV_CUTOUT       8'h49
`define WR_LOCK            8'h71
`define WR_SAVE            8'h72

// status bits
`define ST_LOW_SUPPLY      0
`define ST_HIGH_SUPPLY     1

// lock bits
`define LK_DRIVE           1
`define LK_REGEN           2
`define LK_RISE            3
`define LK_UV_CUTOUT       4
`define LK_UV_RESUME       5
`define LK_OV_RESUME       6
`define LK_OV_CUTOUT       7

// reset values and limits
`define RST_FIELD          12'h000
`define RST_OV_RESUME      12'hA28
`define OV_CUTOUT_CEIL     12'hA8D
`define HEAT_MIN_C         12'h00A
`define HEAT_MAX_C         12'h050

`endif

// [hw/motor_param_pkg.sv]
// Purpose: shared types of the parameter bank
// Assumes: nothing
// Notes:   constants live in motor_param_defs.svh
package motor_param_pkg;

    typedef enum logic [1:0] {
        SUPPLY_OK   = 2'b00,
        SUPPLY_LOW  = 2'b01,
        SUPPLY_HIGH = 2'b10
    } supply_state_type;

endpackage

// [hw/pot_tracked_reg.sv]
// Purpose: one limit register that follows a potentiometer reading
// Assumes: pot reading comes from logic on the same clock
// Notes:   host write wins over a pot change in the same cycle
`timescale 1ns/1ps
module pot_tracked_reg #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // pot and lock
    input  wire logic [WIDTH-1:0] pot_value,
    input  wire logic             lock,
    // host write
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    // register value
    output logic      [WIDTH-1:0] value
);

    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] pot_prev_r;
    logic             pot_moved;

    initial begin
        if (WIDTH < 1) begin
            $error("pot_tracked_reg: WIDTH must be positive");
        end
    end

    assign pot_moved = (pot_value != pot_prev_r);
    assign value     = value_r;

    // reading seen at the last edge, the reference for detecting a pot change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pot_prev_r <= '0;
        end else begin
            pot_prev_r <= pot_value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= '0;
        end else if (wr_en) begin
            value_r <= wr_data;
        end else if (pot_moved && !lock) begin
            value_r <= pot_value;
        end
    end

endmodule // pot_tracked_reg

// [hw/motor_param_register_bank.sv]
// Purpose: parameter and measurement register bank of a DC motor drive
// Assumes: command decoded from the serial link, one command a cycle
// Notes:   all values volatile; saving is requested, not performed here
// Behaviour
// - drive ceiling: read 0x02, write 0x42, 12 bits
// - pot-backed limits follow their pot after startup
// - host write replaces pot until pot moves
// - pot change overwrites the register again
// - lock bit stops pot overwrite
// - values volatile; saved only on host request
// - regen ceiling: 0x03/0x43, same pot behaviour
// - rise ramp: 0x04/0x44, follows ramp pot
// - fall ramp: 0x05/0x45, off, no pot
// - thresholds active only when written and locked
// - undervolt cutout 0x06/0x46 shuts output off
// - undervolt shutdown sets the status flag
// - undervolt resume 0x07/0x47 ends low state
// - overvolt resume 0x08/0x48 ends high state
// - overvolt cutout 0x09/0x49; internal ceiling may rewrite
// - overvolt shutdown sets the status flag
// - heatsink temperature 0x0A, read-only, 10 to 80
// - board temperature 0x0B, read-only, 12 bits
// - supply reading 0x10, read-only, 12 bits
// - status bit 0 low, bit 1 high supply
// - lock bit 3 guards rise ramp
// - lock bit 2 guards regen ceiling
`timescale 1ns/1ps
`include "motor_param_defs.svh"
module motor_param_register_bank
    import motor_param_pkg::*;
#(
    parameter int FIELD_W = `FIELD_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // command port
    input  wire logic               cmd_valid,
    input  wire logic [`CODE_W-1:0] cmd_code,
    input  wire logic [FIELD_W-1:0] cmd_wdata,
    // answer port
    output logic                    rsp_valid,
    output logic      [FIELD_W-1:0] rsp_data,
    output logic                    rsp_err,
    // digitised potentiometers
    input  wire logic [FIELD_W-1:0] drive_pot,
    input  wire logic [FIELD_W-1:0] regen_pot,
    input  wire logic [FIELD_W-1:0] ramp_pot,
    // measurements
    input  wire logic [FIELD_W-1:0] heatsink_meas,
    input  wire logic [FIELD_W-1:0] board_meas,
    input  wire logic [FIELD_W-1:0] supply_meas,
    // register values to the drive
    output logic      [FIELD_W-1:0] drive_amp_ceiling,
    output logic      [FIELD_W-1:0] regen_amp_ceiling,
    output logic      [FIELD_W-1:0] rise_ramp_rate,
    output logic      [FIELD_W-1:0] fall_ramp_rate,
    // supply supervision
    output logic                    output_enable,
    output logic                    low_supply_flag,
    output logic                    high_supply_flag,
    // save request
    output logic                    save_req,
    output logic      [FIELD_W-1:0] save_bits
);

    supply_state_type   sup_state_r;
    supply_state_type   sup_state_nxt;
    logic [`LOCK_W-1:0] lock_r;
    logic [FIELD_W-1:0] fall_ramp_r;
    logic [FIELD_W-1:0] uv_cutout_r;
    logic [FIELD_W-1:0] uv_resume_r;
    logic [FIELD_W-1:0] ov_resume_r;
    logic [FIELD_W-1:0] ov_cutout_r;
    logic [3:0]         thr_written_r;
    logic [FIELD_W-1:0] heatsink_celsius_r;
    logic [FIELD_W-1:0] board_celsius_r;
    logic [FIELD_W-1:0] supply_level_reading_r;
    logic               rsp_valid_r;
    logic [FIELD_W-1:0] rsp_data_r;
    logic               rsp_err_r;
    logic               save_req_r;
    logic [FIELD_W-1:0] save_bits_r;
    logic               uv_cut_on;
    logic               uv_res_on;
    logic               ov_res_on;
    logic               ov_cut_on;
    logic [FIELD_W-1:0] status_word;
    logic [FIELD_W-1:0] ov_cutout_lim;

    initial begin
        if (FIELD_W != `FIELD_W) begin
            $error("motor_param_register_bank: FIELD_W must be 12");
        end
    end

    // single-cycle decode of one write code
    function automatic logic wr_hit(input logic             v,
                                    input logic [`CODE_W-1:0] code,
                                    input logic [`CODE_W-1:0] want);
        wr_hit = v && (code == want);
    endfunction

    // threshold live only when written and locked
    function automatic logic thr_live(input logic written,
                                      input logic locked);
        thr_live = written && locked;
    endfunction

    // clamp a reading into a closed range
    function automatic logic [FIELD_W-1:0] clamp(
        input logic [FIELD_W-1:0] v,
        input logic [FIELD_W-1:0] lo,
        input logic [FIELD_W-1:0] hi);
        if (v < lo) begin
            clamp = lo;
        end else if (v > hi) begin
            clamp = hi;
        end else begin
            clamp = v;
        end
    endfunction

    // pot-backed limit registers
    pot_tracked_reg #(
        .WIDTH     (FIELD_W)
    ) u_drive (
        .clk       (clk),
        .rst_n     (rst_n),
        .pot_value (drive_pot),
        .lock      (lock_r[`LK_DRIVE]),
        .wr_en     (wr_hit(cmd_valid, cmd_code, `WR_DRIVE_AMP)),
        .wr_data   (cmd_wdata),
        .value     (drive_amp_ceiling)
    );

    pot_tracked_reg #(
        .WIDTH     (FIELD_W)
    ) u_regen (
        .clk       (clk),
        .rst_n     (rst_n),
        .pot_value (regen_pot),
        .lock      (lock_r[`LK_REGEN]),
        .wr_en     (wr_hit(cmd_valid, cmd_code, `WR_REGEN_AMP)),
        .wr_data   (cmd_wdata),
        .value     (regen_amp_ceiling)
    );

    pot_tracked_reg #(
        .WIDTH     (FIELD_W)
    ) u_rise (
        .clk       (clk),
        .rst_n     (rst_n),
        .pot_value (ramp_pot),
        .lock      (lock_r[`LK_RISE]),
        .wr_en     (wr_hit(cmd_valid, cmd_code, `WR_RISE_RAMP)),
        .wr_data   (cmd_wdata),
        .value     (rise_ramp_rate)
    );

    // lock register; cleared at restart like every value but the ov resume level and heatsink reading
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_r <= '0;
        end else if (wr_hit(cmd_valid, cmd_code, `WR_LOCK)) begin
            lock_r <= cmd_wdata[`LOCK_W-1:0];
        end
    end

    // fall ramp: zero means disabled, no pot behind it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_ramp_r <= `RST_FIELD;
        end else if (wr_hit(cmd_valid, cmd_code, `WR_FALL_RAMP)) begin
            fall_ramp_r <= cmd_wdata;
        end
    end

    assign fall_ramp_rate = fall_ramp_r;

    // internal ceiling rewrites an over-high cutout level
    assign ov_cutout_lim = (cmd_wdata > `OV_CUTOUT_CEIL) ?
                           `OV_CUTOUT_CEIL : cmd_wdata;

    // threshold registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_cutout_r <= `RST_FIELD;
            uv_resume_r <= `RST_FIELD;
            ov_resume_r <= `RST_OV_RESUME;
            ov_cutout_r <= `RST_FIELD;
        end else if (cmd_valid) begin
            if (cmd_code == `WR_UV_CUTOUT) begin
                uv_cutout_r <= cmd_wdata;
            end
            if (cmd_code == `WR_UV_RESUME) begin
                uv_resume_r <= cmd_wdata;
            end
            if (cmd_code == `WR_OV_RESUME) begin
                ov_resume_r <= cmd_wdata;
            end
            if (cmd_code == `WR_OV_CUTOUT) begin
                ov_cutout_r <= ov_cutout_lim;
            end
        end
    end

    // written marks: uv cutout, uv resume, ov resume, ov cutout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_written_r <= 4'h0;
        end else if (cmd_valid) begin
            if (cmd_code == `WR_UV_CUTOUT) begin
                thr_written_r[0] <= 1'b1;
            end
            if (cmd_code == `WR_UV_RESUME) begin
                thr_written_r[1] <= 1'b1;
            end
            if (cmd_code == `WR_OV_RESUME) begin
                thr_written_r[2] <= 1'b1;
            end
            if (cmd_code == `WR_OV_CUTOUT) begin
                thr_written_r[3] <= 1'b1;
            end
        end
    end

    assign uv_cut_on = thr_live(thr_written_r[0], lock_r[`LK_UV_CUTOUT]);
    assign uv_res_on = thr_live(thr_written_r[1], lock_r[`LK_UV_RESUME]);
    assign ov_res_on = thr_live(thr_written_r[2], lock_r[`LK_OV_RESUME]);
    assign ov_cut_on = thr_live(thr_written_r[3], lock_r[`LK_OV_CUTOUT]);

    // measurement snapshots; no write path reaches them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heatsink_celsius_r     <= `HEAT_MIN_C;
            board_celsius_r        <= `RST_FIELD;
            supply_level_reading_r <= `RST_FIELD;
        end else begin
            heatsink_celsius_r     <= clamp(heatsink_meas, `HEAT_MIN_C,
                                            `HEAT_MAX_C);
            board_celsius_r        <= board_meas;
            supply_level_reading_r <= supply_meas;
        end
    end

    // supply supervision; a shutdown leaves by its resume level or when its cutout is no longer live
    always_comb begin
        sup_state_nxt = sup_state_r;
        case (sup_state_r)
            SUPPLY_OK: begin
                if (uv_cut_on && supply_level_reading_r < uv_cutout_r) begin
                    sup_state_nxt = SUPPLY_LOW;
                end else if (ov_cut_on &&
                             supply_level_reading_r > ov_cutout_r) begin
                    sup_state_nxt = SUPPLY_HIGH;
                end
            end
            SUPPLY_LOW: begin
                if (!uv_cut_on) begin
                    sup_state_nxt = SUPPLY_OK;
                end else if (uv_res_on &&
                             supply_level_reading_r > uv_resume_r) begin
                    sup_state_nxt = SUPPLY_OK;
                end
            end
            SUPPLY_HIGH: begin
                if (!ov_cut_on) begin
                    sup_state_nxt = SUPPLY_OK;
                end else if (ov_res_on &&
                             supply_level_reading_r < ov_resume_r) begin
                    sup_state_nxt = SUPPLY_OK;
                end
            end
            default: begin
                sup_state_nxt = SUPPLY_OK;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_state_r <= SUPPLY_OK;
        end else begin
            sup_state_r <= sup_state_nxt;
        end
    end

    assign output_enable    = (sup_state_r == SUPPLY_OK);
    assign low_supply_flag  = (sup_state_r == SUPPLY_LOW);
    assign high_supply_flag = (sup_state_r == SUPPLY_HIGH);

    always_comb begin
        status_word                  = '0;
        status_word[`ST_LOW_SUPPLY]  = low_supply_flag;
        status_word[`ST_HIGH_SUPPLY] = high_supply_flag;
    end

    // save request: one-cycle pulse carrying the save bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            save_req_r  <= 1'b0;
            save_bits_r <= `RST_FIELD;
        end else begin
            save_req_r <= wr_hit(cmd_valid, cmd_code, `WR_SAVE);
            if (wr_hit(cmd_valid, cmd_code, `WR_SAVE)) begin
                save_bits_r <= cmd_wdata;
            end
        end
    end

    assign save_req  = save_req_r;
    assign save_bits = save_bits_r;

    // answer one cycle after each command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= '0;
            rsp_err_r   <= 1'b0;
        end else begin
            rsp_valid_r <= cmd_valid;
            if (cmd_valid) begin
                rsp_err_r <= 1'b0;
                case (cmd_code)
                    `RD_DRIVE_AMP: rsp_data_r <= drive_amp_ceiling;
                    `RD_REGEN_AMP: rsp_data_r <= regen_amp_ceiling;
                    `RD_RISE_RAMP: rsp_data_r <= rise_ramp_rate;
                    `RD_FALL_RAMP: rsp_data_r <= fall_ramp_r;
                    `RD_UV_CUTOUT: rsp_data_r <= uv_cutout_r;
                    `RD_UV_RESUME: rsp_data_r <= uv_resume_r;
                    `RD_OV_RESUME: rsp_data_r <= ov_resume_r;
                    `RD_OV_CUTOUT: rsp_data_r <= ov_cutout_r;
                    `RD_HEATSINK:  rsp_data_r <= heatsink_celsius_r;
                    `RD_BOARD:     rsp_data_r <= board_celsius_r;
                    `RD_SUPPLY:    rsp_data_r <= supply_level_reading_r;
                    `RD_STATUS:    rsp_data_r <= status_word;
                    `RD_LOCK: begin
                        rsp_data_r <= {{(FIELD_W-`LOCK_W){1'b0}}, lock_r};
                    end
                    `RD_SAVE:      rsp_data_r <= save_bits_r;
                    `WR_DRIVE_AMP, `WR_REGEN_AMP, `WR_RISE_RAMP,
                    `WR_FALL_RAMP, `WR_UV_CUTOUT, `WR_UV_RESUME,
                    `WR_OV_RESUME, `WR_SAVE: begin
                        rsp_data_r <= cmd_wdata;
                    end
                    `WR_OV_CUTOUT: rsp_data_r <= ov_cutout_lim;
                    `WR_LOCK: begin
                        rsp_data_r <= {{(FIELD_W-`LOCK_W){1'b0}},
                                       cmd_wdata[`LOCK_W-1:0]};
                    end
                    default: begin
                        // measurements have no write code
                        rsp_data_r <= '0;
                        rsp_err_r  <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_data  = rsp_data_r;
    assign rsp_err   = rsp_err_r;

endmodule // motor_param_register_bank

// [verification/motor_param_register_bank_chk.sv]
// Purpose: port-level checks of the parameter bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
`include "motor_param_defs.svh"
module motor_param_register_bank_chk #(
    parameter int FIELD_W = `FIELD_W
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // command and answer
    input wire logic               cmd_valid,
    input wire logic [`CODE_W-1:0] cmd_code,
    input wire logic [FIELD_W-1:0] cmd_wdata,
    input wire logic               rsp_valid,
    input wire logic [FIELD_W-1:0] rsp_data,
    input wire logic               rsp_err,
    // register values and supervision
    input wire logic [FIELD_W-1:0] drive_amp_ceiling,
    input wire logic [FIELD_W-1:0] regen_amp_ceiling,
    input wire logic [FIELD_W-1:0] fall_ramp_rate,
    input wire logic               output_enable,
    input wire logic               low_supply_flag,
    input wire logic               high_supply_flag,
    input wire logic               save_req,
    input wire logic [FIELD_W-1:0] save_bits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer one cycle after a command");
    AST_RSP_IDLE: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without a command");
    AST_DRIVE_WR: assert property (cmd_valid && cmd_code == `WR_DRIVE_AMP
        |=> drive_amp_ceiling == $past(cmd_wdata))
        else $error("drive ceiling write not stored");
    AST_DRIVE_RD: assert property (cmd_valid && cmd_code == `RD_DRIVE_AMP
        |=> rsp_data == $past(drive_amp_ceiling) && !rsp_err)
        else $error("drive ceiling read wrong");
    AST_REGEN_WR: assert property (cmd_valid && cmd_code == `WR_REGEN_AMP
        |=> regen_amp_ceiling == $past(cmd_wdata))
        else $error("regen ceiling write not stored");
    AST_FALL_HOLD: assert property (
        !(cmd_valid && cmd_code == `WR_FALL_RAMP)
        |=> $stable(fall_ramp_rate))
        else $error("fall ramp changed without a write");
    AST_OUT_EN: assert property (output_enable
        == !(low_supply_flag || high_supply_flag))
        else $error("output enable disagrees with supply flags");
    AST_MEAS_RO: assert property (cmd_valid
        && cmd_code inside {8'h4A, 8'h4B, 8'h50}
        |=> rsp_err && rsp_data == '0)
        else $error("write to a measurement not refused");
    AST_OV_CLAMP: assert property (cmd_valid && cmd_code == `WR_OV_CUTOUT
        && cmd_wdata > `OV_CUTOUT_CEIL |=> rsp_data == `OV_CUTOUT_CEIL)
        else $error("overvolt cutout not clamped");
    AST_SAVE: assert property (cmd_valid && cmd_code == `WR_SAVE
        |=> save_req && save_bits == $past(cmd_wdata) ##1 !save_req)
        else $error("save request pulse wrong");
endmodule // motor_param_register_bank_chk

bind motor_param_register_bank motor_param_register_bank_chk #(
    .FIELD_W(FIELD_W)
) u_motor_param_register_bank_chk (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err),
    .drive_amp_ceiling(drive_amp_ceiling),
    .regen_amp_ceiling(regen_amp_ceiling),
    .fall_ramp_rate(fall_ramp_rate), .output_enable(output_enable),
    .low_supply_flag(low_supply_flag), .high_supply_flag(high_supply_flag),
    .save_req(save_req), .save_bits(save_bits)
);

// [verification/host_cmd_model.sv]
// Purpose: host end of the command link, one command at a time
// Assumes: answer stands in the cycle after the taking edge
// Notes:   released code and data lines show the inverse, not the last value
`timescale 1ns/1ps
`include "motor_param_defs.svh"
module host_cmd_model #(
    parameter int FIELD_W = `FIELD_W
) (
    // clock
    input  wire logic               clk,
    // command port
    output logic                    cmd_valid,
    output logic      [`CODE_W-1:0] cmd_code,
    output logic      [FIELD_W-1:0] cmd_wdata,
    // answer port
    input  wire logic               rsp_valid,
    input  wire logic [FIELD_W-1:0] rsp_data,
    input  wire logic               rsp_err
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = '0;
    end

    task automatic xfer(input logic [`CODE_W-1:0] code,
                        input logic [FIELD_W-1:0] wd,
                        output logic ok, output logic [FIELD_W-1:0] rd,
                        output logic err);
        logic [FIELD_W-1:0] d;
        d = wd;
        if (code == `WR_FALL_RAMP && d == '0) begin
            d = 12'h001;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        ok        = rsp_valid;
        rd        = rsp_data;
        err       = rsp_err;
        cmd_valid = 1'b0;
        cmd_code  = ~code;
        cmd_wdata = ~d;
    endtask
endmodule // host_cmd_model

// [verification/motor_param_register_bank_tb_top.sv]
// Purpose: self-checking bench of the parameter bank
// Assumes: host model issues commands, bench drives pots and measurements
// Notes:   expected register image kept in exp_reg, indexed by read code
`timescale 1ns/1ps
`include "motor_param_defs.svh"
module motor_param_register_bank_tb_top;
    logic        clk, rst_n, cmd_valid, rsp_valid, rsp_err;
    logic [7:0]  cmd_code;
    logic [11:0] cmd_wdata, rsp_data, drive_pot, regen_pot, ramp_pot;
    logic [11:0] heatsink_meas, board_meas, supply_meas, save_bits;
    logic [11:0] drv, rgn, rise, fall;
    logic        output_enable, low_supply_flag, high_supply_flag, save_req;
    int          num_errors = 0;
    int          checks = 0;
    int          exp_reg [0:63];
    logic [11:0] pot [0:2];

    motor_param_register_bank u_motor_param_register_bank (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_err(rsp_err), .drive_pot(pot[0]),
        .regen_pot(pot[1]), .ramp_pot(pot[2]),
        .heatsink_meas(heatsink_meas), .board_meas(board_meas),
        .supply_meas(supply_meas), .drive_amp_ceiling(drv),
        .regen_amp_ceiling(rgn), .rise_ramp_rate(rise),
        .fall_ramp_rate(fall), .output_enable(output_enable),
        .low_supply_flag(low_supply_flag),
        .high_supply_flag(high_supply_flag), .save_req(save_req),
        .save_bits(save_bits));

    host_cmd_model u_host_cmd_model (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_err(rsp_err));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(string what, logic [47:0] seen, logic [47:0] want);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, want, seen);
        end
    endtask

    task automatic reset_dut(int n);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (n) @(posedge clk);
        #1;
        rst_n = 1'b1;
        foreach (exp_reg[i]) exp_reg[i] = 0;
        exp_reg[8] = 12'hA28;
        for (int i = 0; i < 3; i++) exp_reg[i + 2] = pot[i];
    endtask

    task automatic wr(logic [7:0] code, logic [11:0] d);
        logic ok, err;
        logic [11:0] rdata;
        int want;
        want = d;
        if (code == `WR_FALL_RAMP && d == 0) want = 1;
        if (code == `WR_OV_CUTOUT && d > `OV_CUTOUT_CEIL)
            want = `OV_CUTOUT_CEIL;
        if (code == `WR_LOCK) want = d & 12'h0FF;
        u_host_cmd_model.xfer(code, d, ok, rdata, err);
        check("wr_valid", ok, 1);
        check("wr_err", err, 0);
        check("wr_echo", rdata, want);
        exp_reg[code - 8'h40] = want;
    endtask

    task automatic rd(logic [7:0] code, int want);
        logic ok, err;
        logic [11:0] rdata;
        u_host_cmd_model.xfer(code, 12'h000, ok, rdata, err);
        check("rd_valid", ok, 1);
        check("rd_data", rdata, want);
    endtask

    // move a pot to a value that surely differs from the last one
    task automatic set_pot(int k);
        @(posedge clk);
        #1;
        pot[k] = pot[k] ^ (12'($urandom) | 12'h001);
        if (!exp_reg[8'h31][k + 1]) exp_reg[k + 2] = pot[k];
    endtask

    task automatic supply(logic [11:0] v, int st);
        @(posedge clk);
        #1;
        supply_meas = v;
        repeat (3) @(posedge clk);
        #1;
        check("low_flag", low_supply_flag, st[0]);
        check("high_flag", high_supply_flag, st[1]);
        check("out_en", output_enable, st == 0);
        rd(`RD_STATUS, st);
        rd(`RD_SUPPLY, v);
    endtask

    initial begin
        #(100000 * 20);
        num_errors++;
        summarize();
    end

    initial begin
        logic ok, err;
        logic [11:0] rdata;
        static int hv [5] = '{5, 10, 45, 80, 200};
        rst_n = 1'b0;
        void'($urandom(32'hE3034A80));
        for (int i = 0; i < 3; i++) pot[i] = 12'($urandom);
        heatsink_meas = 12'd45;
        board_meas = 12'h123;
        supply_meas = 12'd2000;
        reset_dut(16);
        for (int c = 2; c <= 5; c++) rd(c[7:0], exp_reg[c]);
        rd(8'h08, 12'hA28);
        rd(`RD_STATUS, 0);
        for (int c = 8'h42; c <= 8'h49; c++) begin
            wr(c[7:0], 12'($urandom));
            rd(c[7:0] - 8'h40, exp_reg[c - 8'h40]);
        end
        wr(`WR_OV_CUTOUT, 12'hFFF);
        set_pot(0);
        rd(`RD_DRIVE_AMP, exp_reg[2]);
        wr(`WR_LOCK, 12'h30E);
        rd(`RD_LOCK, 12'h00E);
        for (int k = 0; k < 3; k++) begin
            set_pot(k);
            rd(k[7:0] + 8'h02, exp_reg[k + 2]);
        end
        wr(`WR_LOCK, 12'h000);
        set_pot(1);
        rd(`RD_REGEN_AMP, exp_reg[3]);
        foreach (hv[i]) begin
            @(posedge clk);
            #1;
            heatsink_meas = hv[i];
            board_meas = 12'($urandom);
            rd(`RD_HEATSINK, hv[i] < 10 ? 10 : hv[i] > 80 ? 80 : hv[i]);
            rd(`RD_BOARD, board_meas);
        end
        foreach (hv[i]) if (i < 3) begin
            u_host_cmd_model.xfer(i == 2 ? 8'h50 : 8'h4A + i[7:0], 12'h7FF,
                                  ok, rdata, err);
            check("meas_wr_err", err, 1);
            check("meas_wr_data", rdata, 0);
        end
        rd(`RD_HEATSINK, 80);
        wr(`WR_UV_CUTOUT, 12'd1000);
        wr(`WR_UV_RESUME, 12'd1200);
        supply(12'd900, 0);
        wr(`WR_LOCK, 12'h030);
        supply(12'd900, 1);
        supply(12'd1100, 1);
        supply(12'd1300, 0);
        wr(`WR_OV_CUTOUT, 12'd2500);
        wr(`WR_OV_RESUME, 12'd2400);
        wr(`WR_LOCK, 12'h0F0);
        supply(12'd2600, 2);
        supply(12'd2450, 2);
        supply(12'd2300, 0);
        wr(`WR_SAVE, 12'hA5C);
        check("save_req", save_req, 1);
        rd(`RD_SAVE, 12'hA5C);
        reset_dut(2);
        rd(`RD_DRIVE_AMP, pot[0]);
        check("lim_outs", {drv, rgn, rise, fall},
              {pot[0], pot[1], pot[2], 12'h000});
        rd(`RD_FALL_RAMP, 0);
        summarize();
    end
endmodule // motor_param_register_bank_tb_top
